// [include/cnu_pkg.sv]
// shared constants, codes and carriers of the dataway command unit
package cnu_pkg;
	localparam int CLK_PERIOD_NS = 4;
	localparam int DW_PHASE_NS   = 200;
	localparam int DW_PHASE_CYC  =
		(DW_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] DW_PHASE_LAST = 8'(DW_PHASE_CYC - 1);
	localparam int USB_TRIG_NS   = 150;
	localparam logic [5:0] USB_TRIG_CYC =
		6'((USB_TRIG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] TICK_NS = 4'(10);
	localparam logic [3:0] TICK_STEP_NS = 4'(CLK_PERIOD_NS);

	// internal device addresses
	localparam logic [2:0] DEV_REG    = 3'h1;
	localparam logic [2:0] DEV_DATA   = 3'h2;
	localparam logic [2:0] DEV_SCALER = 3'h3;
	localparam logic [2:0] DEV_NAF    = 3'h4;
	localparam logic [2:0] DEV_BUFFER = 3'h5;

	// register block sub-addresses
	localparam logic [4:0] SUB_FW_ID     = 5'h00;
	localparam logic [4:0] SUB_MODE      = 5'h01;
	localparam logic [4:0] SUB_DELAYS    = 5'h02;
	localparam logic [4:0] SUB_USER_SEL  = 5'h03;
	localparam logic [4:0] SUB_INTERVAL  = 5'h05;
	localparam logic [4:0] SUB_LED_SEL   = 5'h06;
	localparam logic [4:0] SUB_OUT_SEL   = 5'h07;
	localparam logic [4:0] SUB_REQUEST_TRIGGER_MASK  = 5'h08;
	localparam logic [4:0] SUB_ACTION    = 5'h0a;
	localparam logic [4:0] SUB_LAM       = 5'h0c;
	localparam logic [4:0] SUB_SERIAL    = 5'h0f;
	localparam logic [4:0] SUB_IN2_CNT   = 5'h10;
	localparam logic [4:0] SUB_EVENT_CNT = 5'h12;
	localparam logic [4:0] SUB_DGG1_DLY  = 5'h14;
	localparam logic [4:0] SUB_DGG1_GATE = 5'h15;
	localparam logic [4:0] SUB_DGG2_DLY  = 5'h16;
	localparam logic [4:0] SUB_DGG2_GATE = 5'h17;

	// action bits
	localparam int ACT_ACQUIRE  = 0;
	localparam int ACT_USB_TRIG = 1;
	localparam int ACT_CLR_ALL  = 2;
	localparam int ACT_CLR_IN2  = 3;

	// user device selector fields: two 3-bit trigger codes, then en/reset
	localparam int SEL_DGG_W  = 3;
	localparam int SEL_CNT_EN = 6;
	localparam int SEL_CNT_RS = 7;

	// control stations served by the unit itself
	localparam logic [4:0] N_CTRL    = 5'h1c;
	localparam logic [4:0] N_INHIBIT = 5'h1d;
	localparam logic [4:0] N_COUNTER = 5'h19;
	localparam logic [3:0] A_INIT    = 4'h8;
	localparam logic [3:0] A_CLEAR   = 4'h9;
	localparam logic [4:0] F_CTRL    = 5'h10;

	typedef enum {K_NONE, K_REG_RD, K_REG_WR, K_DW, K_INIT, K_CLEAR,
		K_INHIBIT, K_COUNTER} cnu_kind_e;
	typedef enum {ST_IDLE, ST_SETUP, ST_S1, ST_GAP, ST_S2,
		ST_DONE} cnu_state_e;
	typedef enum {DG_IDLE, DG_DELAY, DG_GATE} cnu_dgg_e;

	typedef struct packed {
		logic [2:0]  dev;
		logic [4:0]  n;
		logic [3:0]  a;
		logic [4:0]  f;
		logic [23:0] data;
	} cnu_cmd_s;

	typedef struct packed {
		logic [23:0] data;
		logic        q;
		logic        x;
	} cnu_rsp_s;

	typedef struct packed {
		logic        busy;
		logic [4:0]  n;
		logic [3:0]  a;
		logic [4:0]  f;
		logic [23:0] wdata;
		logic        wdata_oe;
		logic        s1;
		logic        s2;
		logic        z;
		logic        c;
		logic        inhibit;
	} cnu_dw_s;

	typedef struct packed {
		logic [15:0]      global_mode;
		logic [15:0]      delays;
		logic [15:0]      interval;
		logic [15:0]      led_sel;
		logic [15:0]      out_sel;
		logic [23:0]      request_trigger_mask;
		logic             acquire;
		logic [15:0]      user_sel;
		logic [1:0][15:0] dgg_delay;
		logic [1:0][15:0] dgg_gate;
	} cnu_regs_s;
endpackage

// [verilog/cnu_command_unit.sv]
// dataway command unit: single cycles, register block, gates, counters
`timescale 1ns/1ps
module cnu_command_unit
	import cnu_pkg::*;
#(
	parameter logic [15:0] FIRMWARE_IDENTIFICATION = 16'h5a3c, // arbitrary value
	parameter logic [10:0] SERIAL_NUM  = 11'h001,
	parameter int          SCALER_W    = 32
) (
	input  logic              clk,
	input  logic              sys_rst,
	input  logic              cmd_valid,
	output logic              cmd_ready,
	input  cnu_cmd_s          cmd,
	output logic              rsp_valid,
	output cnu_rsp_s          rsp,
	output cnu_dw_s           dw,
	input  logic [23:0]       dw_rdata,
	input  logic              dw_q,
	input  logic              dw_x,
	input  logic [23:0]       dw_lam,
	input  logic              nim_in1,
	input  logic              nim_in2,
	input  logic              event_trig,
	input  logic              end_of_event,
	input  logic              pulser,
	input  logic              counter_clk_first,
	input  logic              counter_clk_second,
	output wire logic [1:0]   dgg_gate,
	output logic              usb_trig,
	output logic              acquire
);
	if (SCALER_W <= 24 || SCALER_W > 48) begin : g_bad_width
		$error("SCALER_W must lie between 25 and 48");
	end

	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);

	function automatic cnu_kind_e cmd_kind(input cnu_cmd_s c);
		if (c.dev == DEV_REG)
			return (c.f[4:3] == 2'b10) ? K_REG_WR : K_REG_RD;
		if (c.dev != DEV_NAF)
			return K_NONE;
		if (c.n == N_CTRL && c.a == A_INIT && c.f == F_CTRL)
			return K_INIT;
		if (c.n == N_CTRL && c.a == A_CLEAR && c.f == F_CTRL)
			return K_CLEAR;
		if (c.n == N_INHIBIT && c.a == A_CLEAR && c.f == F_CTRL)
			return K_INHIBIT;
		if (c.n == N_COUNTER && c.f == 5'h00)
			return K_COUNTER;
		return K_DW;
	endfunction

	function automatic logic [SCALER_W-1:0] gray2bin(
		input logic [SCALER_W-1:0] g);
		logic [SCALER_W-1:0] b;
		b[SCALER_W-1] = g[SCALER_W-1];
		for (int i = SCALER_W - 2; i >= 0; i--)
			b[i] = b[i+1] ^ g[i];
		return b;
	endfunction

	cnu_kind_e  kind;
	logic       take;
	cnu_state_e st, next_st;
	logic [7:0] ph, next_ph;
	cnu_cmd_s   cur, next_cur;
	cnu_rsp_s   next_rsp;
	cnu_dw_s    next_dw;
	cnu_regs_s  regs, next_regs;
	logic [23:0] reg_rd;
	logic [5:0]  usb_cnt, next_usb_cnt;
	logic [1:0]  rst_tgl, next_rst_tgl;
	logic [23:0] in2_cnt, next_in2_cnt;
	logic [23:0] ev_cnt, next_ev_cnt;
	logic [4:0]  prev, next_prev;
	logic        usb_prev;
	logic [7:0]  trig;
	logic [3:0]  acc, next_acc;
	logic        tick;
	wire  [1:0]  cnt_clk;
	wire  [SCALER_W-1:0] cnt_val [2];

	assign kind      = cmd_kind(cmd);
	assign cmd_ready = (st == ST_IDLE);
	assign take      = cmd_valid && cmd_ready;
	assign rsp_valid = (st == ST_DONE);
	assign acquire   = regs.acquire;
	assign cnt_clk   = {counter_clk_second, counter_clk_first};

	// register block read mux
	always_comb begin
		reg_rd = 24'h00_0000;
		unique case (cmd.n)
			SUB_FW_ID:     reg_rd = 24'(FIRMWARE_IDENTIFICATION);
			SUB_MODE:      reg_rd = 24'(regs.global_mode);
			SUB_DELAYS:    reg_rd = 24'(regs.delays);
			SUB_USER_SEL:  reg_rd = 24'(regs.user_sel);
			SUB_INTERVAL:  reg_rd = 24'(regs.interval);
			SUB_LED_SEL:   reg_rd = 24'(regs.led_sel);
			SUB_OUT_SEL:   reg_rd = 24'(regs.out_sel);
			SUB_REQUEST_TRIGGER_MASK:  reg_rd = regs.request_trigger_mask;
			// trigger and clear bits are actions, they never read back set
			SUB_ACTION:    reg_rd = 24'(regs.acquire);
			SUB_LAM:       reg_rd = dw_lam;
			SUB_SERIAL:    reg_rd = 24'(SERIAL_NUM);
			SUB_IN2_CNT:   reg_rd = in2_cnt;
			SUB_EVENT_CNT: reg_rd = ev_cnt;
			SUB_DGG1_DLY:  reg_rd = 24'(regs.dgg_delay[0]);
			SUB_DGG1_GATE: reg_rd = 24'(regs.dgg_gate[0]);
			SUB_DGG2_DLY:  reg_rd = 24'(regs.dgg_delay[1]);
			SUB_DGG2_GATE: reg_rd = 24'(regs.dgg_gate[1]);
			default:       reg_rd = 24'h00_0000;
		endcase
	end

	// register writes, action pulses and input counters
	always_comb begin
		logic clr_in2;
		clr_in2      = 1'b0;
		next_regs    = regs;
		next_rst_tgl = rst_tgl;
		next_usb_cnt = (usb_cnt != 6'h00) ? usb_cnt - 6'h01 : 6'h00;
		if (take && kind == K_REG_WR) begin
			unique case (cmd.n)
				SUB_MODE:      next_regs.global_mode = cmd.data[15:0];
				SUB_DELAYS:    next_regs.delays = cmd.data[15:0];
				SUB_INTERVAL:  next_regs.interval = cmd.data[15:0];
				SUB_LED_SEL:   next_regs.led_sel = cmd.data[15:0];
				SUB_OUT_SEL:   next_regs.out_sel = cmd.data[15:0];
				SUB_REQUEST_TRIGGER_MASK:  next_regs.request_trigger_mask = cmd.data;
				SUB_DGG1_DLY:  next_regs.dgg_delay[0] = cmd.data[15:0];
				SUB_DGG1_GATE: next_regs.dgg_gate[0] = cmd.data[15:0];
				SUB_DGG2_DLY:  next_regs.dgg_delay[1] = cmd.data[15:0];
				SUB_DGG2_GATE: next_regs.dgg_gate[1] = cmd.data[15:0];
				SUB_USER_SEL: begin
					next_regs.user_sel = cmd.data[15:0];
					// reset bits are strobes: store zero, toggle the crossing
					next_regs.user_sel[SEL_CNT_RS] = 1'b0;
					next_regs.user_sel[SEL_CNT_RS+2] = 1'b0;
					next_rst_tgl[0] = rst_tgl[0] ^ cmd.data[SEL_CNT_RS];
					next_rst_tgl[1] = rst_tgl[1] ^ cmd.data[SEL_CNT_RS+2];
				end
				SUB_ACTION: begin
					next_regs.acquire = cmd.data[ACT_ACQUIRE];
					if (cmd.data[ACT_USB_TRIG])
						next_usb_cnt = USB_TRIG_CYC;
					clr_in2 = cmd.data[ACT_CLR_IN2] | cmd.data[ACT_CLR_ALL];
				end
				default: ;
			endcase
		end
		// an edge in the clearing cycle still counts once
		next_in2_cnt = (clr_in2 ? 24'h00_0000 : in2_cnt)
			+ 24'(trig[2]);
		next_ev_cnt = ((take && kind == K_REG_WR && cmd.n == SUB_ACTION
			&& cmd.data[ACT_CLR_ALL]) ? 24'h00_0000 : ev_cnt)
			+ 24'(trig[4]);
		next_prev = {pulser, end_of_event, event_trig, nim_in2, nim_in1};
		{tick, next_acc} = {1'b0, acc + TICK_STEP_NS};
		if (next_acc >= TICK_NS) begin
			tick     = 1'b1;
			next_acc = next_acc - TICK_NS;
		end
	end

	// trigger sources by selector code; code 0 disables the generator
	assign trig = {pulser & ~prev[4], usb_trig & ~usb_prev,
		end_of_event & ~prev[3], event_trig & ~prev[2],
		nim_in2 & ~prev[1], nim_in2 & ~prev[1], nim_in1 & ~prev[0], 1'b0};

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			regs     <= '0;
			rst_tgl  <= 2'b00;
			usb_cnt  <= 6'h00;
			usb_trig <= 1'b0;
			usb_prev <= 1'b0;
			in2_cnt  <= 24'h00_0000;
			ev_cnt   <= 24'h00_0000;
			prev     <= 5'h00;
			acc      <= 4'h0;
		end else begin
			regs     <= next_regs;
			rst_tgl  <= next_rst_tgl;
			usb_cnt  <= next_usb_cnt;
			usb_trig <= (next_usb_cnt != 6'h00);
			usb_prev <= usb_trig;
			in2_cnt  <= next_in2_cnt;
			ev_cnt   <= next_ev_cnt;
			prev     <= next_prev;
			acc      <= next_acc;
		end
	end

	a_usb_pulse_len: assert property (
		$rose(usb_trig) |-> ##37 usb_trig ##1 !usb_trig)
		else $error("trigger pulse length is not 38 cycles");
	a_in2_clear: assert property (
		take && kind == K_REG_WR && cmd.n == SUB_ACTION
		&& cmd.data[ACT_CLR_IN2] && !trig[2] |=> in2_cnt == 24'h00_0000)
		else $error("input two counter not cleared");

	// single-cycle sequencer
	always_comb begin
		logic [SCALER_W-1:0] sv;
		sv       = cmd.a[1] ? cnt_val[1] : cnt_val[0];
		next_st  = st;
		next_ph  = ph;
		next_cur = cur;
		next_rsp = rsp;
		next_dw  = dw;
		unique case (st)
			ST_IDLE: if (take) begin
				next_cur = cmd;
				next_rsp = '{data: 24'h00_0000, q: 1'b1, x: 1'b1};
				next_st  = ST_DONE;
				unique case (kind)
					K_REG_RD: next_rsp.data = reg_rd;
					K_REG_WR: ;
					K_INHIBIT: next_dw.inhibit = cmd.data[0];
					// served from the crossing, the dataway stays idle
					K_COUNTER: next_rsp.data = cmd.a[0]
						? 24'(sv >> 24) : sv[23:0];
					// stacks and buffer live outside this block
					K_NONE: next_rsp = '{data: 24'h00_0000, q: 1'b0, x: 1'b0};
					default: begin
						next_st          = ST_SETUP;
						next_ph          = DW_PHASE_LAST;
						next_dw.busy     = 1'b1;
						next_dw.n        = cmd.n;
						next_dw.a        = cmd.a;
						next_dw.f        = cmd.f;
						next_dw.wdata    = cmd.data;
						next_dw.wdata_oe = (kind == K_DW)
							&& (cmd.f[4:3] == 2'b10);
						next_dw.z        = (kind == K_INIT);
						next_dw.c        = (kind == K_CLEAR);
					end
				endcase
			end
			ST_SETUP: if (ph == 8'h00) begin
				next_st    = ST_S1;
				next_ph    = DW_PHASE_LAST;
				// initialize and clear use the second strobe only
				next_dw.s1 = !(dw.z || dw.c);
			end else begin
				next_ph = ph - 8'h01;
			end
			ST_S1: if (ph == 8'h00) begin
				next_st       = ST_GAP;
				next_ph       = DW_PHASE_LAST;
				next_dw.s1    = 1'b0;
				next_rsp.q    = dw_q;
				next_rsp.x    = dw_x;
				next_rsp.data = (cur.f[3] || cur.f[4])
					? 24'h00_0000 : dw_rdata;
			end else begin
				next_ph = ph - 8'h01;
			end
			ST_GAP: if (ph == 8'h00) begin
				next_st    = ST_S2;
				next_ph    = DW_PHASE_LAST;
				next_dw.s2 = 1'b1;
			end else begin
				next_ph = ph - 8'h01;
			end
			ST_S2: if (ph == 8'h00) begin
				next_st          = ST_DONE;
				next_dw.s2       = 1'b0;
				next_dw.busy     = 1'b0;
				next_dw.z        = 1'b0;
				next_dw.c        = 1'b0;
				next_dw.wdata_oe = 1'b0;
			end else begin
				next_ph = ph - 8'h01;
			end
			ST_DONE: next_st = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			st  <= ST_IDLE;
			ph  <= 8'h00;
			cur <= '0;
			rsp <= '0;
			dw  <= '0;
		end else begin
			st  <= next_st;
			ph  <= next_ph;
			cur <= next_cur;
			rsp <= next_rsp;
			dw  <= next_dw;
		end
	end

	a_write_drive: assert property (
		dw.s1 && cur.f[4:3] == 2'b10 && cur.dev == DEV_NAF
		|-> dw.wdata_oe && dw.wdata == cur.data && dw.f == cur.f)
		else $error("write data not on the dataway during strobe");
	a_read_naf: assert property (
		dw.busy |-> dw.n == cur.n && dw.a == cur.a && dw.f == cur.f)
		else $error("dataway address differs from the request");
	a_nondata_zero: assert property (
		rsp_valid && cur.dev == DEV_NAF && cur.f[3] |-> rsp.data == 0)
		else $error("non-data function returned data");
	a_qx_return: assert property (
		st == ST_S1 && ph == 8'h00 |-> ##101 (rsp_valid
		&& rsp.q == $past(dw_q, 101) && rsp.x == $past(dw_x, 101)))
		else $error("Q or X not returned after the cycle");
	a_init_op: assert property (
		take && kind == K_INIT |=> dw.z && dw.busy && !dw.c)
		else $error("initialize not driven on the dataway");
	a_clear_op: assert property (
		take && kind == K_CLEAR |=> dw.c && dw.busy && !dw.z)
		else $error("clear not driven on the dataway");
	a_inhibit_level: assert property (
		take && kind == K_INHIBIT |=> dw.inhibit == $past(cmd.data[0]))
		else $error("inhibit line does not follow written value");
	a_counter_quiet: assert property (
		take && kind == K_COUNTER |=> rsp_valid && !dw.busy)
		else $error("counter read touched the dataway");

	// delay and gate generators, counted in 10 ns ticks
	for (genvar gi = 0; gi < 2; gi++) begin : g_dgg
		cnu_dgg_e    ds, next_ds;
		logic [15:0] dc, next_dc;
		logic        gate;
		logic        go;
		assign go = trig[regs.user_sel[gi*SEL_DGG_W +: SEL_DGG_W]];
		assign dgg_gate[gi] = gate;
		always_comb begin
			next_ds = ds;
			next_dc = dc;
			unique case (ds)
				// a zero delay still waits for the next tick, so a gate
				// spans whole ticks and never shrinks to a single clock
				DG_IDLE: if (go && regs.dgg_gate[gi] != 16'h0000) begin
					next_ds = DG_DELAY;
					next_dc = (regs.dgg_delay[gi] != 16'h0000)
						? regs.dgg_delay[gi] : 16'h0001;
				end
				DG_DELAY: if (tick) begin
					if (dc != 16'h0001) begin
						next_dc = dc - 16'h0001;
					end else if (regs.dgg_gate[gi] != 16'h0000) begin
						next_ds = DG_GATE;
						next_dc = regs.dgg_gate[gi];
					end else begin
						next_ds = DG_IDLE;
					end
				end
				DG_GATE: if (tick) begin
					if (dc != 16'h0001)
						next_dc = dc - 16'h0001;
					else
						next_ds = DG_IDLE;
				end
			endcase
		end
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				ds   <= DG_IDLE;
				dc   <= 16'h0000;
				gate <= 1'b0;
			end else begin
				ds   <= next_ds;
				dc   <= next_dc;
				gate <= (next_ds == DG_GATE);
			end
		end
		a_gate_follows: assert property (
			ds == DG_DELAY && tick && dc == 16'h0001
			&& regs.dgg_gate[gi] != 16'h0000 |=> gate)
			else $error("gate did not follow the delay");
	end

	// user counters, each clocked by its own counter clock input
	for (genvar gi = 0; gi < 2; gi++) begin : g_cnt
		logic [1:0]          en_sync;
		logic [2:0]          rs_sync;
		logic [SCALER_W-1:0] bin, next_bin, gray;
		logic [SCALER_W-1:0] g_meta, g_sync;
		// a clear makes several gray bits move at once; a read landing
		// right on it may show a mix of old and new bits for one sample
		always_comb begin
			next_bin = bin;
			if (rs_sync[2] ^ rs_sync[1])
				next_bin = '0;
			else if (en_sync[1])
				next_bin = bin + 1'b1;
		end
		always_ff @(posedge cnt_clk[gi] or posedge sys_rst) begin
			if (sys_rst) begin
				en_sync <= 2'b00;
				rs_sync <= 3'b000;
				bin     <= '0;
				gray    <= '0;
			end else begin
				en_sync <= {en_sync[0], regs.user_sel[SEL_CNT_EN + 2*gi]};
				rs_sync <= {rs_sync[1:0], rst_tgl[gi]};
				bin     <= next_bin;
				gray    <= next_bin ^ (next_bin >> 1);
			end
		end
		always_ff @(posedge clk or posedge sys_rst) begin
			if (sys_rst) begin
				g_meta <= '0;
				g_sync <= '0;
			end else begin
				g_meta <= gray;
				g_sync <= g_meta;
			end
		end
		assign cnt_val[gi] = gray2bin(g_sync);
	end
endmodule

// [sim/cnu_crate_model.sv]
// crate module model answering single dataway cycles at stations 1 to 23
`timescale 1ns/1ps
module cnu_crate_model
	import cnu_pkg::*;
(
	input  logic        clk,
	input  cnu_dw_s     dw,
	input  logic        slow,
	output logic [23:0] rdata,
	output logic        q,
	output logic        x,
	output logic [23:0] wdata_seen,
	output int          s1_cnt,
	output int          z_cnt,
	output int          c_cnt
);
	int   lag;
	logic s1_d;
	logic z_d;
	logic c_d;

	initial begin
		{rdata, q, x, wdata_seen, s1_d, z_d, c_d} = '0;
		{s1_cnt, z_cnt, c_cnt, lag} = '0;
	end

	always @(posedge clk) begin
		s1_d <= dw.s1;
		z_d <= dw.z;
		c_d <= dw.c;
		if (dw.s1 && !s1_d)
			s1_cnt <= s1_cnt + 1;
		if (dw.z && !z_d)
			z_cnt <= z_cnt + 1;
		if (dw.c && !c_d)
			c_cnt <= c_cnt + 1;
		lag <= dw.s1 ? lag + 1 : 0;
		if (dw.s1 && dw.wdata_oe)
			wdata_seen <= dw.wdata;
		// a slow module settles late in strobe one; lines wander otherwise
		if (dw.s1 && (!slow || lag > 30)) begin
			rdata <= (dw.f[4:3] == 2'b00) ? {dw.n, dw.a, 15'h1234} : ~rdata;
			x <= (dw.n != 5'h00) && (dw.n < 5'h18);
			q <= (dw.n == 5'h05);
		end else begin
			rdata <= ~rdata;
			q <= ~q;
			x <= ~x;
		end
	end
endmodule

// [sim/testbench.sv]
// self-checking bench of the dataway command unit
`timescale 1ns/1ps
module testbench
	import cnu_pkg::*;
;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        cmd_valid = 1'b0;
	cnu_cmd_s    cmd = '0;
	logic [23:0] dw_lam = 24'h81_0042;
	logic        nim_in1 = 1'b0;
	logic        nim_in2 = 1'b0;
	logic        tie_lo = 1'b0;
	logic        pulser = 1'b0;
	logic        counter_clk_first = 1'b0;
	logic        counter_clk_second = 1'b0;
	logic        slow = 1'b0;
	logic        cmd_ready;
	logic        rsp_valid;
	cnu_rsp_s    rsp;
	cnu_dw_s     dw;
	logic [23:0] dw_rdata;
	logic        dw_q;
	logic        dw_x;
	wire  [1:0]  dgg_gate;
	logic        usb_trig;
	logic        acquire;
	logic [23:0] wdata_seen;
	int          s1_cnt;
	int          z_cnt;
	int          c_cnt;
	cnu_rsp_s    r;
	int          lat;
	int          error_cnt = 0;
	int          check_count = 0;
	int          cycles = 0;
	int          trig_hi = 0;
	int          gh0 = 0;
	int          gh1 = 0;

	always #2 clk = ~clk;

	cnu_command_unit #(
		.FIRMWARE_IDENTIFICATION (16'h0c3a), // arbitrary value
		.SERIAL_NUM  (11'h2b5),
		.SCALER_W    (32)
	) uut (
		.clk                (clk),
		.sys_rst            (sys_rst),
		.cmd_valid          (cmd_valid),
		.cmd_ready          (cmd_ready),
		.cmd                (cmd),
		.rsp_valid          (rsp_valid),
		.rsp                (rsp),
		.dw                 (dw),
		.dw_rdata           (dw_rdata),
		.dw_q               (dw_q),
		.dw_x               (dw_x),
		.dw_lam             (dw_lam),
		.nim_in1            (nim_in1),
		.nim_in2            (nim_in2),
		.event_trig         (tie_lo),
		.end_of_event       (tie_lo),
		.pulser             (pulser),
		.counter_clk_first  (counter_clk_first),
		.counter_clk_second (counter_clk_second),
		.dgg_gate           (dgg_gate),
		.usb_trig           (usb_trig),
		.acquire            (acquire)
	);

	cnu_crate_model crate (
		.clk        (clk),
		.dw         (dw),
		.slow       (slow),
		.rdata      (dw_rdata),
		.q          (dw_q),
		.x          (dw_x),
		.wdata_seen (wdata_seen),
		.s1_cnt     (s1_cnt),
		.z_cnt      (z_cnt),
		.c_cnt      (c_cnt)
	);

	// high-time tallies, so pulse widths need no edge race in the tasks
	always @(posedge clk) begin
		cycles <= cycles + 1;
		trig_hi <= trig_hi + int'(usb_trig === 1'b1);
		gh0 <= gh0 + int'(dgg_gate[0] === 1'b1);
		gh1 <= gh1 + int'(dgg_gate[1] === 1'b1);
		if (cycles == 20000) begin
			error_cnt = error_cnt + 1;
			end_sim();
		end
	end

	task automatic end_sim();
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic chk_in(input int got, input int lo, input int hi);
		check_count++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("ERROR %0t: %0d outside %0d..%0d", $time, got, lo, hi);
		end
	endtask

	task automatic run(input logic [2:0] dv, input logic [4:0] n,
		input logic [3:0] a, input logic [4:0] f, input logic [23:0] d);
		int k;
		k = 0;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd <= {dv, n, a, f, d};
		do begin
			@(negedge clk);
			k++;
		end while (cmd_ready !== 1'b1 && k < 20);
		@(posedge clk);
		cmd_valid <= 1'b0;
		lat = 0;
		do begin
			@(negedge clk);
			lat++;
		end while (rsp_valid !== 1'b1 && lat < 400);
		chk(24'(rsp_valid), 24'h00_0001);
		r = rsp;
	endtask

	task automatic reg_wr(input logic [4:0] s, input logic [23:0] d);
		run(DEV_REG, s, 4'h0, 5'h10, d);
	endtask

	task automatic reg_rd(input logic [4:0] s);
		run(DEV_REG, s, 4'h0, 5'h00, 24'h00_0000);
	endtask

	task automatic naf(input logic [4:0] n, input logic [3:0] a,
		input logic [4:0] f, input logic [23:0] d);
		run(DEV_NAF, n, a, f, d);
	endtask

	task automatic t_regs();
		logic [4:0] rw[5] = '{SUB_MODE, SUB_DELAYS, SUB_INTERVAL,
			SUB_LED_SEL, SUB_OUT_SEL};
		logic [2:0] other[3] = '{DEV_DATA, DEV_SCALER, DEV_BUFFER};
		foreach (rw[i])
			reg_wr(rw[i], 24'h00_a5c0 + 24'(i));
		reg_wr(SUB_REQUEST_TRIGGER_MASK, 24'ha5_5a3c);
		reg_wr(SUB_FW_ID, 24'h00_ffff);
		chk_in(lat, 1, 1);
		foreach (rw[i]) begin
			reg_rd(rw[i]);
			chk(r.data, 24'h00_a5c0 + 24'(i));
		end
		reg_rd(SUB_REQUEST_TRIGGER_MASK);
		chk(r.data, 24'ha5_5a3c);
		reg_rd(SUB_FW_ID);
		chk(r.data, 24'h00_0c3a);
		reg_rd(SUB_SERIAL);
		chk(r.data, 24'h00_02b5);
		reg_rd(SUB_LAM);
		chk(r.data, 24'h81_0042);
		foreach (other[i]) begin
			run(other[i], 5'h05, 4'h0, 5'h00, 24'h00_0000);
			chk({r.data[21:0], r.q, r.x}, 24'h00_0000);
		end
	endtask

	task automatic t_dway();
		logic [4:0] nd[4] = '{5'h08, 5'h0f, 5'h18, 5'h1f};
		int s;
		s = s1_cnt;
		naf(5'h05, 4'h3, 5'h00, 24'h00_0000);
		chk(r.data, {5'h05, 4'h3, 15'h1234});
		chk(24'({r.q, r.x}), 24'h00_0003);
		chk_in(s1_cnt - s, 1, 1);
		slow <= 1'b1;
		naf(5'h06, 4'h2, 5'h07, 24'h00_0000);
		slow <= 1'b0;
		chk(r.data, {5'h06, 4'h2, 15'h1234});
		chk(24'({r.q, r.x}), 24'h00_0001);
		naf(5'h18, 4'h0, 5'h00, 24'h00_0000);
		chk(24'({r.q, r.x}), 24'h00_0000);
		foreach (nd[i]) begin
			naf(5'h05, 4'h1, nd[i], 24'h00_0000);
			chk(r.data, 24'h00_0000);
			chk(24'({r.q, r.x}), 24'h00_0003);
		end
		naf(5'h05, 4'h1, 5'h10, 24'hc3_5a96);
		chk(wdata_seen, 24'hc3_5a96);
		chk(24'({r.q, r.x}), 24'h00_0003);
		naf(5'h06, 4'h4, 5'h17, 24'h3c_a569);
		chk(wdata_seen, 24'h3c_a569);
		chk(24'({r.q, r.x}), 24'h00_0001);
	endtask

	task automatic t_ctrl();
		int s;
		int z;
		int c;
		s = s1_cnt;
		z = z_cnt;
		c = c_cnt;
		naf(N_CTRL, A_INIT, F_CTRL, 24'h00_0000);
		chk_in(z_cnt - z, 1, 1);
		chk_in(c_cnt - c, 0, 0);
		naf(N_CTRL, A_CLEAR, F_CTRL, 24'h00_0000);
		chk_in(c_cnt - c, 1, 1);
		chk_in(s1_cnt - s, 0, 0);
		naf(N_INHIBIT, A_CLEAR, F_CTRL, 24'h00_0001);
		chk(24'(dw.inhibit), 24'h00_0001);
		repeat (30) @(posedge clk);
		chk(24'(dw.inhibit), 24'h00_0001);
		naf(N_INHIBIT, A_CLEAR, F_CTRL, 24'h00_0000);
		chk(24'(dw.inhibit), 24'h00_0000);
	endtask

	task automatic t_action();
		int t;
		t = trig_hi;
		reg_wr(SUB_ACTION, 24'h00_0003);
		chk(24'(acquire), 24'h00_0001);
		repeat (60) @(posedge clk);
		chk_in(trig_hi - t, int'(USB_TRIG_CYC), int'(USB_TRIG_CYC));
		reg_rd(SUB_ACTION);
		chk(r.data & 24'h00_0003, 24'h00_0001);
		reg_wr(SUB_ACTION, 24'h00_0000);
		chk(24'(acquire), 24'h00_0000);
		repeat (3) begin
			@(posedge clk) nim_in2 <= 1'b1;
			@(posedge clk) nim_in2 <= 1'b0;
		end
		reg_rd(SUB_IN2_CNT);
		chk(r.data, 24'h00_0003);
		reg_wr(SUB_ACTION, 24'h00_0008);
		reg_rd(SUB_IN2_CNT);
		chk(r.data, 24'h00_0000);
	endtask

	// counter clocks run off the system clock phase on purpose
	task automatic tick(input int k, input bit second);
		repeat (k) begin
			#3;
			if (second)
				counter_clk_second = 1'b1;
			else
				counter_clk_first = 1'b1;
			#4;
			counter_clk_first = 1'b0;
			counter_clk_second = 1'b0;
		end
		repeat (20) @(posedge clk);
	endtask

	task automatic t_count();
		int s;
		reg_wr(SUB_USER_SEL, 24'h00_0140);
		tick(10, 1'b0);
		tick(4, 1'b1);
		s = s1_cnt;
		naf(N_COUNTER, 4'h0, 5'h00, 24'h00_0000);
		// the enable takes two counter clock edges to cross over
		chk(r.data, 24'h00_0008);
		chk_in(s1_cnt - s, 0, 0);
		naf(N_COUNTER, 4'h1, 5'h00, 24'h00_0000);
		chk(r.data, 24'h00_0000);
		naf(N_COUNTER, 4'h2, 5'h00, 24'h00_0000);
		chk(r.data, 24'h00_0002);
		reg_wr(SUB_USER_SEL, 24'h00_0000);
		// two more edges count while the disable crosses
		tick(5, 1'b0);
		naf(N_COUNTER, 4'h0, 5'h00, 24'h00_0000);
		chk(r.data, 24'h00_000a);
		reg_wr(SUB_USER_SEL, 24'h00_0080);
		tick(3, 1'b0);
		naf(N_COUNTER, 4'h0, 5'h00, 24'h00_0000);
		chk(r.data, 24'h00_0000);
	endtask

	task automatic t_gate();
		int d;
		int g;
		reg_wr(SUB_DGG1_DLY, 24'h00_0005);
		reg_wr(SUB_DGG1_GATE, 24'h00_0004);
		reg_wr(SUB_DGG2_DLY, 24'h00_0000);
		reg_wr(SUB_DGG2_GATE, 24'h00_0001);
		reg_wr(SUB_USER_SEL, 24'h00_0011);
		g = gh0;
		d = 0;
		@(posedge clk) nim_in1 <= 1'b1;
		@(posedge clk) nim_in1 <= 1'b0;
		while (dgg_gate[0] !== 1'b1 && d < 100) begin
			@(negedge clk);
			d++;
		end
		chk_in(d, 10, 18);
		repeat (40) @(posedge clk);
		chk_in(gh0 - g, 9, 11);
		g = gh1;
		@(posedge clk) nim_in2 <= 1'b1;
		@(posedge clk) nim_in2 <= 1'b0;
		repeat (20) @(posedge clk);
		chk_in(gh1 - g, 2, 3);
		reg_rd(SUB_DGG1_GATE);
		chk(r.data, 24'h00_0004);
		reg_wr(SUB_USER_SEL, 24'h00_0038);
		g = gh1;
		// the gate must follow the rising edge, long before the fall
		@(posedge clk) pulser <= 1'b1;
		repeat (9) @(posedge clk);
		pulser <= 1'b0;
		chk_in(gh1 - g, 2, 3);
	endtask

	initial begin
		repeat (12) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_dway();
		t_ctrl();
		t_action();
		t_count();
		t_gate();
		end_sim();
	end
endmodule
